// >>> design/apss_sequencer.v
// Automatic preset scan sequencer with its APB register file.
`timescale 1ns/100ps
`include "apss_regs.vh"
module apss_sequencer #(
  parameter [24:0] TICK_CYCLES = `APSS_TICK_CYCLES
) (
  // Clock and reset
  input  wire        clock,
  input  wire        rstn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // Drive status pin
  input  wire        driveFault,
  // Drive outputs
  output reg  [3:0]  activePreset,
  output reg  [2:0]  rampSelect,
  output reg         stopRequest
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_RUN  = 3'b010;
  localparam [2:0] ST_DONE = 3'b100;

  // Software-visible state.
  reg  [31:0] ctrl;
  reg  [1:0]  scanMode;
  reg         modeChanged;

  // Bus state.
  reg         accessWait;
  wire        busAccess;
  wire        busDone;
  wire        busWrite;
  wire        hitCtrl;
  wire        hitMode;
  wire        hitStatus;
  wire        hitDwell;
  wire        hitAny;

  // Fault pin synchroniser.
  reg         faultMeta;
  reg         faultSync;

  // Sequencer state.
  reg  [2:0]  state;
  reg  [2:0]  presetIdx;
  reg  [15:0] elapsed;
  reg         settle;
  wire        tick;
  wire [15:0] dwellNow;
  wire [15:0] busDwell;
  wire [15:0] dwellWrite;
  wire        scanReset;
  wire        scanHalt;
  wire        dwellReached;
  wire        lastPreset;
  wire        wiringLatched;
  wire        tickRun;
  wire        tickClear;
  wire        autoSelect;
  wire [2:0]  manualIdx;
  wire [2:0]  selectedIdx;
  wire [1:0]  modeWrite;
  wire [2:0]  wiringMode;
  wire [2:0]  manualRamp;
  wire        inRun;
  wire        inDone;
  wire [31:0] statusWord;

  assign autoSelect = ctrl[`APSS_CTRL_AUTO_BIT];
  assign manualIdx  = ctrl[`APSS_CTRL_MANSEL_MSB:`APSS_CTRL_MANSEL_LSB];
  assign manualRamp = ctrl[`APSS_CTRL_MANRAMP_MSB:`APSS_CTRL_MANRAMP_LSB];
  assign wiringMode = ctrl[`APSS_CTRL_WIRING_MSB:`APSS_CTRL_WIRING_LSB];
  assign inRun      = (state == ST_RUN);
  assign inDone     = (state == ST_DONE);

  // Register decode.
  assign hitCtrl   = (paddr == `APSS_CTRL_OFS);
  assign hitMode   = (paddr == `APSS_MODE_OFS);
  assign hitStatus = (paddr == `APSS_STATUS_OFS);
  assign hitDwell  = (paddr >= `APSS_DWELL_BASE_OFS) && (paddr <= `APSS_DWELL_LAST_OFS) &&
                     (paddr[1:0] == 2'h0);
  assign hitAny    = hitCtrl | hitMode | hitStatus | hitDwell;

  // Every access takes one wait cycle so the registered dwell read is ready.
  assign busAccess = psel && penable;
  assign pready    = busAccess && accessWait;
  assign busDone   = pready;
  assign busWrite  = busDone && pwrite;
  assign pslverr   = busDone && !hitAny;

  always @(posedge clock) begin
    if (!rstn) begin
      accessWait <= 1'b0;
    end else if (busDone) begin
      accessWait <= 1'b0;
    end else if (busAccess) begin
      accessWait <= 1'b1;
    end
  end

  // Dwell writes above the ceiling are clamped rather than wrapping to a short time.
  assign dwellWrite = (pwdata[15:0] > `APSS_DWELL_MAX) ? `APSS_DWELL_MAX : pwdata[15:0];

  apss_dwell_mem uDwell (
    .clock     (clock),
    .rstn      (rstn),
    .writeEn   (busWrite && hitDwell),
    .writeAddr (paddr[4:2]),
    .writeData (dwellWrite),
    .busAddr   (paddr[4:2]),
    .busData   (busDwell),
    .seqAddr   (presetIdx),
    .seqData   (dwellNow)
  );

  // Control and mode registers.
  assign modeWrite = pwdata[`APSS_MODE_MSB:`APSS_MODE_LSB];

  always @(posedge clock) begin
    if (!rstn) begin
      ctrl        <= `APSS_CTRL_RESET;
      scanMode    <= `APSS_MODE_RESET;
      modeChanged <= 1'b0;
    end else begin
      modeChanged <= 1'b0;
      if (busWrite && hitCtrl) begin
        ctrl <= pwdata & `APSS_CTRL_MASK;
      end
      // A value of 3 is refused and the old mode stays.
      if (busWrite && hitMode && modeWrite <= `APSS_MODE_PASS_HOLD) begin
        scanMode <= modeWrite;
        if (modeWrite != scanMode) begin
          modeChanged <= 1'b1;
        end
      end
    end
  end

  // The fault level comes from the drive's protection logic on another timing path.
  always @(posedge clock) begin
    if (!rstn) begin
      faultMeta <= 1'b0;
      faultSync <= 1'b0;
    end else begin
      faultMeta <= driveFault;
      faultSync <= faultMeta;
    end
  end

  assign scanReset = !autoSelect || ctrl[`APSS_CTRL_RESET_BIT] || modeChanged;
  assign scanHalt  = faultSync || ctrl[`APSS_CTRL_HALT_BIT];

  // The timer runs only in the run state, as long as nothing resets or halts it.
  assign tickRun   = inRun && !scanHalt && !scanReset;
  assign tickClear = scanReset || !inRun || settle;

  apss_tick_gen #(
    .TICK_CYCLES (TICK_CYCLES)
  ) uTick (
    .clock (clock),
    .rstn  (rstn),
    .run   (tickRun),
    .clear (tickClear),
    .tick  (tick)
  );

  // The dwell store answers a cycle after the index moves, so settle masks that cycle.
  assign dwellReached  = !settle && (elapsed >= dwellNow);
  assign lastPreset    = (presetIdx == 3'h7);
  assign wiringLatched = (wiringMode == `APSS_WIRING_TWO_THREE) ||
                         (wiringMode == `APSS_WIRING_THREE_SP);

  always @(posedge clock) begin
    if (!rstn) begin
      state       <= ST_IDLE;
      presetIdx   <= 3'h0;
      elapsed     <= 16'h0000;
      settle      <= 1'b1;
      stopRequest <= 1'b0;
    end else begin
      stopRequest <= 1'b0;
      if (scanReset) begin
        state     <= ST_IDLE;
        presetIdx <= 3'h0;
        elapsed   <= 16'h0000;
        settle    <= 1'b1;
      end else if (scanHalt) begin
        state <= state;
      end else begin
        case (state)
          ST_IDLE: begin
            state  <= ST_RUN;
            settle <= 1'b1;
          end
          ST_RUN: begin
            if (settle) begin
              settle <= 1'b0;
            end else if (dwellReached) begin
              elapsed <= 16'h0000;
              if (!lastPreset) begin
                presetIdx <= presetIdx + 3'h1;
                settle    <= 1'b1;
              end else begin
                case (scanMode)
                  `APSS_MODE_FOREVER: begin
                    presetIdx <= 3'h0;
                    settle    <= 1'b1;
                  end
                  `APSS_MODE_PASS_HALT: begin
                    // Under two-wire wiring nothing latches the run, so no stop is sent.
                    state       <= ST_DONE;
                    stopRequest <= wiringLatched;
                  end
                  default: begin
                    state <= ST_DONE;
                  end
                endcase
              end
            end else if (tick) begin
              elapsed <= elapsed + 16'h0001;
            end
          end
          ST_DONE: begin
            state <= ST_DONE;
          end
          default: begin
            state     <= ST_IDLE;
            presetIdx <= 3'h0;
          end
        endcase
      end
    end
  end

  // Preset selection: the sequencer under autoselect, the manual bits otherwise.
  assign selectedIdx = autoSelect ? presetIdx : manualIdx;

  always @(posedge clock) begin
    if (!rstn) begin
      activePreset <= 4'h1;
      rampSelect   <= 3'h0;
    end else begin
      activePreset <= {1'b0, selectedIdx} + 4'h1;
      if (ctrl[`APSS_CTRL_RAMP_BIT]) begin
        rampSelect <= selectedIdx;
      end else begin
        rampSelect <= manualRamp;
      end
    end
  end

  // Status word as software sees it; the halted bit covers both the fault and the halt request.
  assign statusWord[31:8]                                         = 24'h000000;
  assign statusWord[`APSS_STAT_FAULT_BIT]                         = faultSync;
  assign statusWord[`APSS_STAT_HALT_BIT]                          = scanHalt;
  assign statusWord[`APSS_STAT_DONE_BIT]                          = inDone;
  assign statusWord[`APSS_STAT_RUN_BIT]                           = inRun;
  assign statusWord[`APSS_STAT_PRESET_MSB:`APSS_STAT_PRESET_LSB] = activePreset;

  // Read data is captured in the first access cycle and presented with pready.
  always @(posedge clock) begin
    if (!rstn) begin
      prdata <= 32'h00000000;
    end else if (busAccess && !accessWait && !pwrite) begin
      if (hitCtrl) begin
        prdata <= ctrl;
      end else if (hitMode) begin
        prdata <= {30'h00000000, scanMode};
      end else if (hitStatus) begin
        prdata <= statusWord;
      end else if (hitDwell) begin
        prdata <= {16'h0000, busDwell};
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

endmodule

// >>> inc/apss_regs.vh
// Register offsets, field positions, reset values and timing counts of the preset scan sequencer.
`ifndef APSS_REGS_VH
`define APSS_REGS_VH

// Byte offsets on the APB register port.
`define APSS_CTRL_OFS        8'h00
`define APSS_MODE_OFS        8'h04
`define APSS_STATUS_OFS      8'h08
`define APSS_DWELL_BASE_OFS  8'h20
`define APSS_DWELL_LAST_OFS  8'h3c

// Control register fields.
`define APSS_CTRL_AUTO_BIT     0
`define APSS_CTRL_RESET_BIT    1
`define APSS_CTRL_HALT_BIT     2
`define APSS_CTRL_RAMP_BIT     3
`define APSS_CTRL_MANSEL_LSB   4
`define APSS_CTRL_MANSEL_MSB   6
`define APSS_CTRL_MANRAMP_LSB  8
`define APSS_CTRL_MANRAMP_MSB  10
`define APSS_CTRL_WIRING_LSB   12
`define APSS_CTRL_WIRING_MSB   14
`define APSS_CTRL_MASK         32'h0000777f
`define APSS_CTRL_RESET        32'h00000000

// Mode register field and its settings.
`define APSS_MODE_LSB          0
`define APSS_MODE_MSB          1
`define APSS_MODE_FOREVER      2'h0
`define APSS_MODE_PASS_HALT    2'h1
`define APSS_MODE_PASS_HOLD    2'h2
`define APSS_MODE_RESET        2'h0

// Status register fields.
`define APSS_STAT_PRESET_LSB   0
`define APSS_STAT_PRESET_MSB   3
`define APSS_STAT_RUN_BIT      4
`define APSS_STAT_DONE_BIT     5
`define APSS_STAT_HALT_BIT     6
`define APSS_STAT_FAULT_BIT    7

// Start/stop wiring settings that latch a stop command.
`define APSS_WIRING_TWO_THREE  3'h1
`define APSS_WIRING_THREE_SP   3'h2

// Dwell times in 0.1 s ticks: 20.0 s default, 3276.0 s ceiling.
`define APSS_DWELL_RESET       16'h00c8
`define APSS_DWELL_MAX         16'h7ff8

// Timing: the tick is 0.1 s, the clock period 5 ns.
`define APSS_TICK_TIME_NS      100000000
`define APSS_CLK_PERIOD_NS     5
`define APSS_TICK_CYCLES       25'h1312d00

`endif

// >>> design/apss_tick_gen.v
// Tenth-of-a-second tick generator that can be cleared and frozen.
`timescale 1ns/100ps
module apss_tick_gen #(
  parameter [24:0] TICK_CYCLES = 25'h1312d00
) (
  // Clock and reset
  input  wire        clock,
  input  wire        rstn,
  // Control
  input  wire        run,
  input  wire        clear,
  // Tick out
  output reg         tick
);

  reg [24:0] count;

  always @(posedge clock) begin
    if (!rstn) begin
      count <= 25'h0000000;
      tick  <= 1'b0;
    end else if (clear) begin
      count <= 25'h0000000;
      tick  <= 1'b0;
    end else if (run) begin
      if (count >= TICK_CYCLES - 25'h0000001) begin
        count <= 25'h0000000;
        tick  <= 1'b1;
      end else begin
        count <= count + 25'h0000001;
        tick  <= 1'b0;
      end
    end else begin
      // Frozen: the partial tick is kept so a halt does not lose time already counted.
      tick <= 1'b0;
    end
  end

endmodule

// >>> design/apss_dwell_mem.v
// Eight-entry dwell-time store with one write port and two registered read ports.
`timescale 1ns/100ps
`include "apss_regs.vh"
module apss_dwell_mem (
  // Clock and reset
  input  wire        clock,
  input  wire        rstn,
  // Write port
  input  wire        writeEn,
  input  wire [2:0]  writeAddr,
  input  wire [15:0] writeData,
  // Read port for the bus
  input  wire [2:0]  busAddr,
  output reg  [15:0] busData,
  // Read port for the sequencer
  input  wire [2:0]  seqAddr,
  output reg  [15:0] seqData
);

  reg [15:0] store [0:7];

  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : gEntry
      always @(posedge clock) begin
        if (!rstn) begin
          store[i] <= `APSS_DWELL_RESET;
        end else if (writeEn && writeAddr == i) begin
          store[i] <= writeData;
        end
      end
    end
  endgenerate

  always @(posedge clock) begin
    if (!rstn) begin
      busData <= 16'h0000;
      seqData <= `APSS_DWELL_RESET;
    end else begin
      busData <= store[busAddr];
      seqData <= store[seqAddr];
    end
  end

endmodule

// >>> verification/apss_sequencer_properties.sv
// Concurrent checks on the ports of the preset scan sequencer.
`timescale 1ns/100ps
`include "apss_regs.vh"
module apss_sequencer_properties (
  // Clock and reset
  input logic        clock,
  input logic        rstn,
  // APB slave
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [7:0]  paddr,
  input logic [31:0] pwdata,
  input logic        pready,
  input logic [31:0] prdata,
  input logic        pslverr,
  // Drive side
  input logic        driveFault,
  input logic [3:0]  activePreset,
  input logic [2:0]  rampSelect,
  input logic        stopRequest
);
  // Shadow of the control word and the cycles since the last write, so checks wait for it to settle.
  logic [31:0] ctrl;
  logic [3:0]  age;
  wire         wrDone = psel && penable && pready && pwrite;

  always @(posedge clock) begin
    if (!rstn) begin
      ctrl <= 32'h0;
      age  <= 4'h0;
    end else begin
      if (wrDone && paddr == `APSS_CTRL_OFS)
        ctrl <= pwdata;
      age <= wrDone ? 4'h0 : (age == 4'hf ? age : age + 4'h1);
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);

  preset_range_a: assert property (activePreset >= 4'h1 && activePreset <= 4'h8)
    else $error("active preset out of range");
  ready_wait_a: assert property (pready |-> psel && penable && $past(psel && penable))
    else $error("pready outside second access cycle");
  slverr_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  stop_pulse_a: assert property (stopRequest |=> !stopRequest)
    else $error("stop request longer than one cycle");
  stop_end_a: assert property (stopRequest |-> activePreset == 4'h8 &&
    (ctrl[14:12] == `APSS_WIRING_TWO_THREE || ctrl[14:12] == `APSS_WIRING_THREE_SP))
    else $error("stop request without pass end or latched wiring");
  auto_step_a: assert property (ctrl[0] && $changed(activePreset) |->
    activePreset == $past(activePreset) + 4'h1 || activePreset == 4'h1)
    else $error("preset did not step upward");
  manual_preset_a: assert property (age >= 4'h3 && !ctrl[0] |-> activePreset == {1'b0, ctrl[6:4]} + 4'h1)
    else $error("manual preset not shown");
  manual_ramp_a: assert property (age >= 4'h5 && !ctrl[3] |-> rampSelect == ctrl[10:8])
    else $error("manual ramp not applied");
  halt_freeze_a: assert property (age >= 4'h5 && (ctrl[2] || driveFault && $past(driveFault, 5)) && !ctrl[1]
    |-> $stable(activePreset))
    else $error("preset moved while halted");
  reset_hold_a: assert property (age >= 4'h5 && ctrl[0] && ctrl[1] |-> activePreset == 4'h1)
    else $error("preset not held at one under reset");
endmodule

bind apss_sequencer apss_sequencer_properties i_props (
  .clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .driveFault(driveFault),
  .activePreset(activePreset), .rampSelect(rampSelect), .stopRequest(stopRequest)
);

// >>> verification/apss_sequencer_tb_top.sv
// Self-checking bench for the preset scan sequencer.
`timescale 1ns/100ps
`include "apss_regs.vh"
module apss_sequencer_tb_top;
  logic        clock;
  logic        rstn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        driveFault;
  logic [3:0]  activePreset;
  logic [2:0]  rampSelect;
  logic        stopRequest;
  logic [31:0] rdata;
  logic        rerr;
  logic [3:0]  held;
  int          mismatches = 0;
  int          checks = 0;
  int          stops = 0;

  // A short tick keeps each dwell step to a few cycles.
  apss_sequencer #(.TICK_CYCLES(25'd4)) i_dut (
    .clock        (clock),
    .rstn         (rstn),
    .psel         (psel),
    .penable      (penable),
    .pwrite       (pwrite),
    .paddr        (paddr),
    .pwdata       (pwdata),
    .pready       (pready),
    .prdata       (prdata),
    .pslverr      (pslverr),
    .driveFault   (driveFault),
    .activePreset (activePreset),
    .rampSelect   (rampSelect),
    .stopRequest  (stopRequest)
  );

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  always @(posedge clock) begin
    if (stopRequest === 1'b1)
      stops <= stops + 1;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("Checks made %0d, mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // The release takes its own cycle so no signal is driven twice in one time step.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      mismatches++;
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(what, rdata, exp);
  endtask

  task automatic waitp(input logic [3:0] exp);
    int n;
    n = 0;
    while (activePreset !== exp && n < 300) begin
      @(posedge clock);
      n++;
    end
    chk("preset", activePreset, exp);
  endtask

  initial begin
    int n;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    driveFault = 1'b0;
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    rd("ctrl", `APSS_CTRL_OFS, `APSS_CTRL_RESET);
    rd("mode", `APSS_MODE_OFS, 32'h0);
    for (int i = 0; i < 8; i++)
      rd("dwell", `APSS_DWELL_BASE_OFS + 8'(4 * i), {16'h0, `APSS_DWELL_RESET});
    rd("unmapped", 8'h10, 32'h0);
    chk("slverr", rerr, 32'h1);
    chk("preset", activePreset, 4'h1);
    wr(`APSS_CTRL_OFS, 32'h350);
    repeat (4) @(posedge clock);
    chk("preset", activePreset, 4'h6);
    chk("ramp", rampSelect, 3'h3);
    wr(`APSS_MODE_OFS, 32'h3);
    rd("mode", `APSS_MODE_OFS, 32'h0);
    wr(`APSS_DWELL_BASE_OFS + 8'h4, 32'hffff);
    rd("dwell", `APSS_DWELL_BASE_OFS + 8'h4, {16'h0, `APSS_DWELL_MAX});
    for (int i = 0; i < 8; i++)
      wr(`APSS_DWELL_BASE_OFS + 8'(4 * i), 32'h2);
    wr(`APSS_CTRL_OFS, 32'h351);
    for (int p = 2; p <= 10; p++)
      waitp(4'((p - 1) % 8 + 1));
    n = 0;
    while (activePreset === 4'h2 && n < 100) begin
      @(posedge clock);
      n++;
    end
    chk("dwell span", 32'(n >= 8 && n <= 14), 32'h1);
    wr(`APSS_CTRL_OFS, 32'h355);
    repeat (2) @(posedge clock);
    held = activePreset;
    repeat (40) @(posedge clock);
    chk("halt", activePreset, held);
    rd("status", `APSS_STATUS_OFS, 32'h50 | 32'(held));
    chk("status preset", rdata[3:0], held);
    wr(`APSS_CTRL_OFS, 32'h35d);
    repeat (3) @(posedge clock);
    chk("ramp follow", rampSelect, 3'(held - 4'h1));
    wr(`APSS_CTRL_OFS, 32'h357);
    repeat (4) @(posedge clock);
    chk("reset wins", activePreset, 4'h1);
    wr(`APSS_CTRL_OFS, 32'h351);
    waitp(4'h2);
    driveFault <= 1'b1;
    repeat (5) @(posedge clock);
    held = activePreset;
    repeat (40) @(posedge clock);
    chk("fault", activePreset, held);
    rd("status fault", `APSS_STATUS_OFS, 32'hd0 | 32'(held));
    driveFault <= 1'b0;
    waitp(held % 4'h8 + 4'h1);
    waitp(4'h3);
    wr(`APSS_MODE_OFS, 32'h2);
    repeat (3) @(posedge clock);
    chk("mode change", activePreset, 4'h1);
    waitp(4'h8);
    repeat (60) @(posedge clock);
    chk("hold", activePreset, 4'h8);
    chk("stops", stops, 32'h0);
    rd("status done", `APSS_STATUS_OFS, 32'h28);
    wr(`APSS_MODE_OFS, 32'h1);
    repeat (2) @(posedge clock);
    waitp(4'h8);
    repeat (30) @(posedge clock);
    chk("stops", stops, 32'h0);
    for (int w = 1; w <= 2; w++) begin
      wr(`APSS_CTRL_OFS, 32'h353 | 32'(w << 12));
      wr(`APSS_CTRL_OFS, 32'h351 | 32'(w << 12));
      waitp(4'h8);
      repeat (30) @(posedge clock);
      chk("stops", stops, 32'(w));
    end
    end_of_test();
  end

  initial begin
    #100000;
    mismatches++;
    end_of_test();
  end
endmodule
